/* File: common/rtm_defines.vh */
/*
  Constants of the reloadable timer: register offsets, control field
  positions, mode codes, status bit positions and reset values.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef RTM_DEFINES_VH
`define RTM_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------------
`define RTM_OFS_CTRL     8'h00
`define RTM_OFS_COUNT    8'h04
`define RTM_OFS_RELOAD   8'h08
`define RTM_OFS_CMP      8'h0c
`define RTM_OFS_CAPTURE  8'h10
`define RTM_OFS_STATUS   8'h14
`define RTM_OFS_MASK     8'h18
`define RTM_OFS_STATE    8'h1c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define RTM_CTRL_EN      0
`define RTM_CTRL_MODE_LO 1
`define RTM_CTRL_MODE_HI 3
`define RTM_CTRL_POL     4
`define RTM_CTRL_PRE_LO  5
`define RTM_CTRL_PRE_HI  7
`define RTM_CTRL_W       8

// ----------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------
`define RTM_MODE_ONESHOT 3'h0
`define RTM_MODE_CONT    3'h1
`define RTM_MODE_COUNTER 3'h2
`define RTM_MODE_PWM     3'h3
`define RTM_MODE_CAPTURE 3'h4
`define RTM_MODE_COMPARE 3'h5
`define RTM_MODE_GATED   3'h6

// ----------------------------------------------------------------------
// Status / mask bits
// ----------------------------------------------------------------------
`define RTM_ST_RELOAD    0
`define RTM_ST_CAPTURE   1
`define RTM_ST_GATE      2
`define RTM_ST_MATCH     3
`define RTM_ST_W         4

// ----------------------------------------------------------------------
// Reset values and misc
// ----------------------------------------------------------------------
`define RTM_CTRL_RST     8'h00
`define RTM_CNT_START    16'h0001
`define RTM_RELOAD_RST   16'hffff
`define RTM_CMP_RST      16'h0000
`define RTM_MASK_RST     4'h0
`define RTM_HTRANS_BIT   1
`define RTM_ADDR_W       8
`define RTM_PRE_DIV_W    7

`endif

/* File: src/rtm_prescaler.v */
/*
  Power-of-two prescaler: one tick every 2^div_sel clocks (1 to 128).
  Assumes run and div_sel come from logic on ref_clk.
*/
`timescale 1ns/1ns
`include "rtm_defines.vh"

module rtm_prescaler #(
  parameter DIV_W = 7
) (
  input  wire         ref_clk,
  input  wire         srst,
  input  wire         run,
  input  wire [2:0]   div_sel,
  output wire         tick
);

  reg  [DIV_W-1:0] div_cnt_ff;
  wire [DIV_W-1:0] nxt_div_cnt;
  wire [DIV_W-1:0] div_mask;

  function [DIV_W-1:0] sel_mask;
    input [2:0] s;
    begin
      sel_mask = ~({DIV_W{1'b1}} << s);
    end
  endfunction

  assign div_mask    = sel_mask(div_sel);
  // Cleared while stopped so the first tick after enable is a full period
  assign nxt_div_cnt = run ? (div_cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1}) : {DIV_W{1'b0}};
  assign tick        = run && ((div_cnt_ff & div_mask) == div_mask);

  always @(posedge ref_clk) begin
    if (srst) begin
      div_cnt_ff <= {DIV_W{1'b0}};
    end else begin
      div_cnt_ff <= nxt_div_cnt;
    end
  end

endmodule // rtm_prescaler

/* File: src/rtm_input_sync.v */
/*
  Two-flop synchroniser for the timer input pin plus edge detection.
  Assumes the pin toggles no faster than a quarter of ref_clk.
*/
`timescale 1ns/1ns

module rtm_input_sync (
  input  wire         ref_clk,
  input  wire         srst,
  input  wire         pin_in,
  output wire         level,
  output wire         rise,
  output wire         fall
);

  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  always @(posedge ref_clk) begin
    if (srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
  assign fall  = ~sync_ff & prev_ff;

endmodule // rtm_input_sync

/* File: src/rtm_timer.v */
/*
  Reloadable 16-bit timer with prescaler, input pin modes, output pin
  and interrupt, reached over an AHB-Lite slave port.
  Assumes a single AHB-Lite master, word accesses only, and one clock.
*/
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
// Notes on behaviour
// - 16-bit counter restarts at 1 after reaching 16-bit reload value
// - Prescaler divides clock by 1 to 128
// - Input pin counts, gates or triggers capture
// - Disabled output equals polarity bit
// - Enabled output inverts on every reload outside PWM mode
// - Counter mode output toggles after reload
// - Counter mode polarity picks counting edge
// - PWM polarity 0: low idle, high match
// - PWM polarity 1: high idle, low match
// - Capture latches count on selected edge
// - Gated polarity 0: count high, irq fall
// - Gated polarity 1: count low, irq rise
`timescale 1ns/1ns
`include "rtm_defines.vh"

module rtm_timer #(
  parameter CNT_W = 16
) (
  input  wire             ref_clk,
  input  wire             srst,
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output wire             hreadyout,
  output wire             hresp,
  output reg  [31:0]      hrdata,
  input  wire             tmr_in,
  output wire             tmr_out,
  output wire             tmr_irq
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [`RTM_CTRL_W-1:0]  ctrl_ff;
  reg  [CNT_W-1:0]        count_ff;
  reg  [CNT_W-1:0]        reload_ff;
  reg  [CNT_W-1:0]        cmp_ff;
  reg  [CNT_W-1:0]        capture_ff;
  reg  [`RTM_ST_W-1:0]    status_ff;
  reg  [`RTM_ST_W-1:0]    mask_ff;
  reg                     out_ff;
  reg                     wr_pend_ff;
  reg  [`RTM_ADDR_W-1:0]  wr_addr_ff;

  reg  [`RTM_CTRL_W-1:0]  nxt_ctrl;
  reg  [CNT_W-1:0]        nxt_count;
  reg  [CNT_W-1:0]        nxt_capture;
  reg  [`RTM_ST_W-1:0]    nxt_status;
  reg                     nxt_out;
  reg  [CNT_W-1:0]        nxt_reload;
  reg  [CNT_W-1:0]        nxt_cmp;
  reg  [`RTM_ST_W-1:0]    nxt_mask;
  reg  [31:0]             nxt_hrdata;

  // --------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------
  wire                    en   = ctrl_ff[`RTM_CTRL_EN];
  wire [2:0]              mode = ctrl_ff[`RTM_CTRL_MODE_HI:`RTM_CTRL_MODE_LO];
  wire                    pol  = ctrl_ff[`RTM_CTRL_POL];
  wire [2:0]              pre  = ctrl_ff[`RTM_CTRL_PRE_HI:`RTM_CTRL_PRE_LO];

  function [31:0] pad_word;
    input [CNT_W-1:0] v;
    begin
      pad_word = {{(32-CNT_W){1'b0}}, v};
    end
  endfunction

  // One decode for every register write, so the offsets cannot drift apart
  function wr_hit;
    input                   pend;
    input [`RTM_ADDR_W-1:0] addr;
    input [`RTM_ADDR_W-1:0] ofs;
    begin
      wr_hit = pend && (addr == ofs);
    end
  endfunction

  // --------------------------------------------------------------------
  // Input pin and prescaler
  // --------------------------------------------------------------------
  wire in_lvl;
  wire in_rise;
  wire in_fall;
  wire pre_tick;

  rtm_input_sync u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pin_in  (tmr_in),
    .level   (in_lvl),
    .rise    (in_rise),
    .fall    (in_fall)
  );

  // Counter mode counts pin edges, so the prescaler is idle there
  rtm_prescaler #(
    .DIV_W (`RTM_PRE_DIV_W)
  ) u_pre (
    .ref_clk (ref_clk),
    .srst    (srst),
    .run     (en && (mode != `RTM_MODE_COUNTER)),
    .div_sel (pre),
    .tick    (pre_tick)
  );

  // --------------------------------------------------------------------
  // Event decode
  // --------------------------------------------------------------------
  wire sel_edge  = pol ? in_fall : in_rise;
  wire gate_open = pol ? ~in_lvl : in_lvl;
  wire gate_edge = pol ? in_rise : in_fall;

  reg advance;
  always @* begin
    advance = 1'b0;
    case (mode)
      `RTM_MODE_COUNTER: advance = en & sel_edge;
      `RTM_MODE_GATED:   advance = en & pre_tick & gate_open;
      default:           advance = en & pre_tick;
    endcase
  end

  wire hit_reload = advance && (count_ff == reload_ff);
  wire hit_cmp    = advance && (count_ff == cmp_ff);
  wire cap_ev     = en && (mode == `RTM_MODE_CAPTURE) && sel_edge;
  wire gate_ev    = en && (mode == `RTM_MODE_GATED) && gate_edge;
  wire match_ev   = hit_cmp && ((mode == `RTM_MODE_PWM) || (mode == `RTM_MODE_COMPARE));

  // --------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------
  // Zero wait states: reads are fetched at the address phase edge
  wire                   acc    = hsel && htrans[`RTM_HTRANS_BIT] && hready;
  wire                   rd_acc = acc && !hwrite;
  wire [`RTM_ADDR_W-1:0] a_ofs  = haddr[`RTM_ADDR_W-1:0];
  wire                   wr_ctl = wr_hit(wr_pend_ff, wr_addr_ff, `RTM_OFS_CTRL);
  wire                   wr_cnt = wr_hit(wr_pend_ff, wr_addr_ff, `RTM_OFS_COUNT);
  wire                   wr_rld = wr_hit(wr_pend_ff, wr_addr_ff, `RTM_OFS_RELOAD);
  wire                   wr_cmp = wr_hit(wr_pend_ff, wr_addr_ff, `RTM_OFS_CMP);
  wire                   wr_msk = wr_hit(wr_pend_ff, wr_addr_ff, `RTM_OFS_MASK);
  wire                   rd_st  = rd_acc && (a_ofs == `RTM_OFS_STATUS);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @* begin
    nxt_hrdata = 32'h0000_0000;
    if (rd_acc) begin
      case (a_ofs)
        `RTM_OFS_CTRL:    nxt_hrdata = {24'h00_0000, ctrl_ff};
        `RTM_OFS_COUNT:   nxt_hrdata = pad_word(count_ff);
        `RTM_OFS_RELOAD:  nxt_hrdata = pad_word(reload_ff);
        `RTM_OFS_CMP:     nxt_hrdata = pad_word(cmp_ff);
        `RTM_OFS_CAPTURE: nxt_hrdata = pad_word(capture_ff);
        `RTM_OFS_STATUS:  nxt_hrdata = {28'h000_0000, status_ff};
        `RTM_OFS_MASK:    nxt_hrdata = {28'h000_0000, mask_ff};
        `RTM_OFS_STATE:   nxt_hrdata = {30'h0, in_lvl, out_ff};
        default:          nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Control and counter next state
  // --------------------------------------------------------------------
  always @* begin
    nxt_ctrl = ctrl_ff;
    // One-shot stops itself at its reload
    if (hit_reload && (mode == `RTM_MODE_ONESHOT)) begin
      nxt_ctrl[`RTM_CTRL_EN] = 1'b0;
    end
    if (wr_ctl) begin
      nxt_ctrl = hwdata[`RTM_CTRL_W-1:0];
    end
  end

  always @* begin
    nxt_count = count_ff;
    if (hit_reload) begin
      nxt_count = `RTM_CNT_START;
    end else if (advance) begin
      nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (wr_cnt) begin
      nxt_count = hwdata[CNT_W-1:0];
    end
  end

  always @* begin
    nxt_capture = capture_ff;
    if (cap_ev) begin
      nxt_capture = count_ff;
    end
  end

  // --------------------------------------------------------------------
  // Software-only registers
  // --------------------------------------------------------------------
  // Bus writes land at the end of their data phase
  always @* begin
    nxt_reload = reload_ff;
    nxt_cmp    = cmp_ff;
    nxt_mask   = mask_ff;
    if (wr_rld) begin
      nxt_reload = hwdata[CNT_W-1:0];
    end
    if (wr_cmp) begin
      nxt_cmp = hwdata[CNT_W-1:0];
    end
    if (wr_msk) begin
      nxt_mask = hwdata[`RTM_ST_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // Timer output
  // --------------------------------------------------------------------
  always @* begin
    nxt_out = out_ff;
    if (!en) begin
      nxt_out = pol;
    end else if (mode == `RTM_MODE_PWM) begin
      // Reload is tested first, so it wins over a match on the same count
      if (hit_reload) begin
        nxt_out = pol;
      end else if (hit_cmp) begin
        nxt_out = ~pol;
      end
    end else if (hit_reload) begin
      nxt_out = ~out_ff;
    end
  end

  assign tmr_out = out_ff;

  // --------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------
  // A new event in the read cycle survives the read-clear
  always @* begin
    nxt_status = rd_st ? {`RTM_ST_W{1'b0}} : status_ff;
    if (hit_reload) begin
      nxt_status[`RTM_ST_RELOAD] = 1'b1;
    end
    if (cap_ev) begin
      nxt_status[`RTM_ST_CAPTURE] = 1'b1;
    end
    if (gate_ev) begin
      nxt_status[`RTM_ST_GATE] = 1'b1;
    end
    if (match_ev) begin
      nxt_status[`RTM_ST_MATCH] = 1'b1;
    end
  end

  assign tmr_irq = |(status_ff & mask_ff);

  // --------------------------------------------------------------------
  // Flip-flops
  // --------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_ff    <= `RTM_CTRL_RST;
      count_ff   <= `RTM_CNT_START;
      reload_ff  <= `RTM_RELOAD_RST;
      cmp_ff     <= `RTM_CMP_RST;
      capture_ff <= {CNT_W{1'b0}};
      status_ff  <= {`RTM_ST_W{1'b0}};
      mask_ff    <= `RTM_MASK_RST;
      out_ff     <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= {`RTM_ADDR_W{1'b0}};
      hrdata     <= 32'h0000_0000;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      count_ff   <= nxt_count;
      capture_ff <= nxt_capture;
      status_ff  <= nxt_status;
      out_ff     <= nxt_out;
      wr_pend_ff <= acc && hwrite;
      wr_addr_ff <= a_ofs;
      hrdata     <= nxt_hrdata;
      reload_ff  <= nxt_reload;
      cmp_ff     <= nxt_cmp;
      mask_ff    <= nxt_mask;
    end
  end

endmodule // rtm_timer

/* File: testbench/rtm_timer_properties.sv */
/*
  Port checker of rtm_timer with its bind.
  Assumes hready is tied to hreadyout and word accesses only.
*/
`timescale 1ns/1ns
`include "rtm_defines.vh"
module rtm_timer_chk #(
  parameter CNT_W = 16
) (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        tmr_in,
  input wire logic        tmr_out,
  input wire logic        tmr_irq
);
  // ----------
  // Register shadows
  // ----------
  logic [8:0] wa_ff;
  logic [7:0] ctrl_ff;
  logic [3:0] mask_ff;
  wire take  = hsel && htrans[1] && hready;
  wire st_rd = take && !hwrite && haddr[7:0] == `RTM_OFS_STATUS;
  // Shadow only sees software; a one-shot self-disable stays invisible
  always @(posedge ref_clk) begin
    if (srst) begin
      wa_ff   <= 9'h000;
      ctrl_ff <= `RTM_CTRL_RST;
      mask_ff <= `RTM_MASK_RST;
    end else begin
      wa_ff <= {take && hwrite, haddr[7:0]};
      if (wa_ff == {1'b1, `RTM_OFS_CTRL}) ctrl_ff <= hwdata[7:0];
      if (wa_ff == {1'b1, `RTM_OFS_MASK}) mask_ff <= hwdata[3:0];
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_READY: assert property (hreadyout == 1'b1) else $error("wait state seen");
  AST_OKAY: assert property (hresp == 1'b0) else $error("error response");
  AST_RD_IDLE: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside a read");
  AST_RD_WIDTH: assert property (hrdata[31:CNT_W] == '0) else $error("upper bits set");
  AST_RST: assert property (disable iff (1'b0) srst |=> !tmr_out && !tmr_irq)
    else $error("pins not cleared by reset");
  AST_DIS_OUT: assert property (!ctrl_ff[0] && $past(!ctrl_ff[0]) && $stable(ctrl_ff[4])
    |-> tmr_out == ctrl_ff[4]) else $error("disabled level wrong");
  AST_IRQ_MASK: assert property (mask_ff == 4'h0 |-> !tmr_irq) else $error("masked irq");
  AST_IRQ_HOLD: assert property ($fell(tmr_irq) |-> $past(st_rd) || $past(srst)
    || $past(mask_ff) != mask_ff) else $error("irq dropped unasked");
endmodule // rtm_timer_chk

bind rtm_timer rtm_timer_chk #(.CNT_W(CNT_W)) i_rtm_timer_chk (
  .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tmr_in(tmr_in),
  .tmr_out(tmr_out), .tmr_irq(tmr_irq));

/* File: testbench/rtm_pin_model.sv */
/*
  Far-side driver of the timer input pin.
  Assumes calls start right after a rising edge of ref_clk.
*/
`timescale 1ns/1ns
module rtm_pin_model (
  input wire logic ref_clk,
  output logic     tmr_in
);
  initial tmr_in = 1'b0;
  // Four clocks per level keeps the pin at a quarter of the clock rate
  task automatic drive(input logic v);
    tmr_in <= v;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      drive(~tmr_in);
      drive(~tmr_in);
    end
  endtask
endmodule // rtm_pin_model

/* File: testbench/tb_rtm_timer.sv */
/*
  Self-checking bench of rtm_timer over AHB-Lite.
  Assumes the pin model and the bound port checker.
*/
`timescale 1ns/1ns
`include "rtm_defines.vh"
module tb_rtm_timer;
  localparam [7:0] a_ctl = `RTM_OFS_CTRL;
  localparam [7:0] a_cnt = `RTM_OFS_COUNT;
  localparam [7:0] a_rld = `RTM_OFS_RELOAD;
  localparam [7:0] a_st  = `RTM_OFS_STATUS;
  logic        ref_clk;
  logic        srst;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hready;
  logic        hresp;
  logic        tmr_in;
  logic        tmr_out;
  logic        tmr_irq;
  int          error_cnt;
  int          checks;
  rtm_timer #(.CNT_W(16)) i_rtm_timer (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .tmr_in(tmr_in),
    .tmr_out(tmr_out), .tmr_irq(tmr_irq));
  rtm_pin_model i_rtm_pin_model (.ref_clk(ref_clk), .tmr_in(tmr_in));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // Skips three level changes so a settings change has settled, then times
  // a whole level of the same kind as the first skipped change led into
  task automatic meas(input logic [31:0] e);
    logic v;
    int   n;
    for (int i = 0; i < 4; i++) begin
      v = tmr_out;
      n = 0;
      while (tmr_out === v && n < 2000) begin
        @(posedge ref_clk);
        n++;
      end
    end
    chk(n, e);
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    #400000;
    error_cnt++;
    stop_test;
  end
  initial begin
    {srst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    hsize = 3'h2;
    error_cnt = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rdc(a_cnt, 32'h1);
    rdc(a_rld, 32'hffff);
    rdc(`RTM_OFS_MASK, 32'h0);
    wr(8'h20, 32'h5a);
    rdc(8'h20, 32'h0);
    wr(`RTM_OFS_CMP, 32'habcd);
    rdc(`RTM_OFS_CMP, 32'habcd);
    $display("test regs done");
    for (int m = 0; m < 8; m++) for (int p = 0; p < 2; p++) begin
      wr(a_ctl, {24'h0, 3'h0, p[0], m[2:0], 1'b0});
      repeat (2) @(posedge ref_clk);
      chk(tmr_out, p);
    end
    wr(a_rld, 32'h3);
    for (int p = 0; p < 8; p++) begin
      wr(a_ctl, {24'h0, p[2:0], 1'b0, `RTM_MODE_CONT, 1'b1});
      meas(32'h3 << p);
    end
    wr(a_ctl, 32'h0);
    wr(`RTM_OFS_MASK, 32'h1);
    @(posedge ref_clk);
    chk(tmr_irq, 1'b1);
    rdc(a_st, 32'h1);
    chk(tmr_irq, 1'b0);
    wr(a_cnt, 32'h1);
    wr(a_ctl, {24'h0, 3'h0, 1'b0, `RTM_MODE_ONESHOT, 1'b1});
    repeat (8) @(posedge ref_clk);
    rdc(a_ctl, 32'h0);
    rdc(a_st, 32'h1);
    $display("test continuous done");
    wr(a_rld, 32'h8);
    wr(`RTM_OFS_CMP, 32'h3);
    for (int p = 0; p < 2; p++) begin
      wr(a_ctl, {24'h0, 3'h0, p[0], `RTM_MODE_PWM, 1'b1});
      for (int n = 0; n < 100 && tmr_out !== p[0]; n++) @(posedge ref_clk);
      meas(32'h5);
    end
    wr(a_ctl, {24'h0, 3'h0, 1'b0, `RTM_MODE_COMPARE, 1'b1});
    bus(1'b0, a_st, 32'h0);
    meas(32'h8);
    rdc(a_st, 32'h9);
    wr(a_ctl, 32'h0);
    wr(a_cnt, 32'h1);
    wr(a_ctl, {24'h0, 3'h0, 1'b0, `RTM_MODE_COUNTER, 1'b1});
    i_rtm_pin_model.pulse(8);
    chk(tmr_out, 1'b1);
    rdc(a_cnt, 32'h1);
    wr(a_rld, 32'hffff);
    for (int p = 0; p < 2; p++) begin
      wr(a_ctl, 32'h0);
      wr(a_cnt, 32'h1);
      wr(a_ctl, {24'h0, 3'h0, p[0], `RTM_MODE_COUNTER, 1'b1});
      i_rtm_pin_model.pulse(5);
      rdc(a_cnt, 32'h6);
    end
    for (int p = 0; p < 2; p++) begin
      wr(a_ctl, 32'h0);
      wr(a_cnt, 32'h1234);
      wr(a_ctl, {24'h0, 3'h7, p[0], `RTM_MODE_CAPTURE, 1'b1});
      i_rtm_pin_model.drive(p[0]);
      bus(1'b0, a_st, 32'h0);
      i_rtm_pin_model.drive(~p[0]);
      rdc(a_st, 32'h2);
      rdc(`RTM_OFS_CAPTURE, 32'h1234);
      i_rtm_pin_model.drive(p[0]);
      rdc(a_st, 32'h0);
    end
    wr(`RTM_OFS_MASK, 32'h4);
    for (int p = 0; p < 2; p++) begin
      i_rtm_pin_model.drive(p[0]);
      wr(a_ctl, {24'h0, 3'h0, p[0], `RTM_MODE_GATED, 1'b1});
      wr(a_cnt, 32'h1);
      bus(1'b0, a_st, 32'h0);
      rdc(a_cnt, 32'h1);
      i_rtm_pin_model.drive(~p[0]);
      chk(tmr_irq, 1'b0);
      i_rtm_pin_model.drive(p[0]);
      chk(tmr_irq, 1'b1);
      bus(1'b0, a_cnt, 32'h0);
      chk(r > 32'h1, 1'b1);
      rdc(a_st, 32'h4);
      chk(tmr_irq, 1'b0);
    end
    $display("test pin modes done");
    stop_test;
  end
endmodule // tb_rtm_timer
